// ===== verification/sba_mem_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// byte memory on the far side of the unit
// ---------------------------------------------------------------
module sba_mem_model (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic stall_in,
	input wire logic rd_valid_in,
	input wire logic [47:0] rd_addr_in,
	output logic rd_ready_out,
	output logic rd_data_valid_out,
	output logic [7:0] rd_data_out,
	input wire logic wr_valid_in,
	input sba_pkg::sba_wr_t wr_in,
	output logic wr_ready_out
);
	import sba_pkg::*;
	logic [7:0] m [0:255]; // byte store, loaded by the bench
	logic tick_r; // lets ready rise only on alternate edges while stalled
	logic took; // read taken at this edge
	assign took = rd_valid_in && rd_ready_out;
	// one read outstanding, data one cycle after the take
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tick_r <= 1'b0;
			rd_ready_out <= 1'b0;
			rd_data_valid_out <= 1'b0;
			rd_data_out <= 8'h00;
			wr_ready_out <= 1'b0;
		end else begin
			tick_r <= ~tick_r;
			rd_ready_out <= rd_valid_in && !took && (!stall_in || tick_r);
			rd_data_valid_out <= took;
			// idle data line flips so a stale byte cannot pass
			rd_data_out <= took ? m[rd_addr_in[10:3]] : ~rd_data_out;
			// stalled stores back up into the unit's queue
			wr_ready_out <= !stall_in;
			if (wr_valid_in && wr_ready_out) begin
				m[wr_in.addr[10:3]] <= wr_in.data;
			end
		end
	end
endmodule : sba_mem_model

// ===== verification/sba_unit_properties.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// port relations of the string arithmetic unit
// ---------------------------------------------------------------
module sba_unit_properties (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic issue_valid_in,
	input sba_pkg::sba_issue_t issue_in,
	input wire logic issue_ready_out,
	input wire logic rd_valid_out,
	input wire logic rd_ready_in,
	input wire logic [47:0] rd_addr_out,
	input wire logic rd_data_valid_in,
	input wire logic [7:0] rd_data_in,
	input wire logic wr_valid_out,
	input wire logic wr_ready_in,
	input sba_pkg::sba_wr_t wr_out,
	input wire logic done_out,
	input wire logic ovf_flag_out,
	input wire logic idx_valid_in,
	input sba_pkg::sba_idx_req_t idx_req_in,
	input wire logic idx_done_out,
	input wire logic [47:0] idx_new_out,
	input wire logic [47:0] tbl_addr_out
);
	import sba_pkg::*;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	logic take; // instruction accepted at this edge
	logic long_src; // source longer than the unit holds
	assign take = issue_valid_in && issue_ready_out;
	assign long_src = issue_in.a.len > MAX_SRC_LEN
		|| issue_in.b.len > MAX_SRC_LEN;
	// ---------------------------------------------------------------
	// short finishes: one quiet cycle, then the done pulse
	// ---------------------------------------------------------------
	sequence quiet_s;
		!rd_valid_out && !done_out;
	endsequence
	sequence end_ok_s;
		done_out && !ovf_flag_out;
	endsequence
	sequence end_ovf_s;
		done_out && ovf_flag_out;
	endsequence
	noop_end_a: assert property (
		take && issue_in.c.len == 16'h0 |=> quiet_s ##1 end_ok_s)
		else $error("empty result did not act as a no-op");
	long_src_a: assert property (
		take && issue_in.c.len != 16'h0 && long_src
		|=> quiet_s ##1 end_ovf_s)
		else $error("oversize source not flagged");
	ovf_done_a: assert property (ovf_flag_out |-> done_out)
		else $error("overflow flag outside done");
	busy_a: assert property (take |=> !issue_ready_out)
		else $error("unit ready right after accepting");
	rd_hold_a: assert property (
		rd_valid_out && !rd_ready_in
		|=> rd_valid_out && $stable(rd_addr_out))
		else $error("read request moved before it was taken");
	wr_hold_a: assert property (
		wr_valid_out && !wr_ready_in |=> wr_valid_out && $stable(wr_out))
		else $error("store changed before it was taken");
	// ---------------------------------------------------------------
	// index updates answer one cycle after the request
	// ---------------------------------------------------------------
	idx_resp_a: assert property (idx_valid_in |=> idx_done_out)
		else $error("index update not answered");
	idx_none_a: assert property (
		idx_valid_in && idx_req_in.mode == SBA_IDX_NONE
		|=> idx_new_out == $past(idx_req_in.init))
		else $error("no-increment index changed");
	idx_part_a: assert property (
		idx_valid_in && idx_req_in.mode == SBA_IDX_PART
		|=> idx_new_out == $past(idx_req_in.init + idx_req_in.no_hit))
		else $error("partial increment wrong");
	idx_full_a: assert property (
		idx_valid_in && idx_req_in.mode == SBA_IDX_FULL
		|=> idx_new_out == $past(idx_req_in.init + idx_req_in.consumed
		+ 48'(idx_req_in.delim_hit)))
		else $error("full increment wrong");
	tbl_addr_a: assert property (
		idx_valid_in |=> tbl_addr_out == $past(idx_req_in.tbl_base
		+ (idx_req_in.init << BYTE_SH) + (48'(idx_req_in.chr) << BYTE_SH)))
		else $error("translate address wrong");
endmodule : sba_unit_properties

bind sba_unit sba_unit_properties u_props (
	.clk_in(clk_in), .rst_n_in(rst_n_in), .issue_valid_in(issue_valid_in),
	.issue_in(issue_in), .issue_ready_out(issue_ready_out),
	.rd_valid_out(rd_valid_out), .rd_ready_in(rd_ready_in),
	.rd_addr_out(rd_addr_out), .rd_data_valid_in(rd_data_valid_in),
	.rd_data_in(rd_data_in), .wr_valid_out(wr_valid_out),
	.wr_ready_in(wr_ready_in), .wr_out(wr_out), .done_out(done_out),
	.ovf_flag_out(ovf_flag_out), .idx_valid_in(idx_valid_in),
	.idx_req_in(idx_req_in), .idx_done_out(idx_done_out),
	.idx_new_out(idx_new_out), .tbl_addr_out(tbl_addr_out)
);

// ===== verification/sba_unit_tb.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// self-checking bench for the string arithmetic unit
// ---------------------------------------------------------------
module sba_unit_tb;
	import sba_pkg::*;
	typedef struct packed {
		logic [7:0] op;
		logic [15:0] la, lb, lc;
		logic [7:0] x;
		logic [63:0] a, b;
		logic [159:0] c;
		logic ovf;
	} sba_row_t;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic issue_valid_in = 1'b0;
	sba_issue_t issue_in = '0;
	logic idx_valid_in = 1'b0;
	sba_idx_req_t idx_req_in = '0;
	logic stall = 1'b0; // memory holds off stores
	logic issue_ready_out, rd_valid_out, rd_ready_in, rd_data_valid_in;
	logic wr_valid_out, wr_ready_in, done_out, ovf_flag_out, idx_done_out;
	logic [47:0] rd_addr_out, idx_new_out, tbl_addr_out;
	logic [7:0] rd_data_in;
	sba_wr_t wr_out;
	int mismatches = 0;
	int n_checks = 0;
	logic got_ovf; // flag seen with done
	logic [159:0] v;
	sba_row_t r;
	sba_row_t rows [12];
	always #25 clk_in = ~clk_in;
	sba_unit DUT (
	.clk_in(clk_in), .rst_n_in(rst_n_in), .issue_valid_in(issue_valid_in),
	.issue_in(issue_in), .issue_ready_out(issue_ready_out),
	.rd_valid_out(rd_valid_out), .rd_ready_in(rd_ready_in),
	.rd_addr_out(rd_addr_out), .rd_data_valid_in(rd_data_valid_in),
	.rd_data_in(rd_data_in), .wr_valid_out(wr_valid_out),
	.wr_ready_in(wr_ready_in), .wr_out(wr_out), .done_out(done_out),
	.ovf_flag_out(ovf_flag_out), .idx_valid_in(idx_valid_in),
	.idx_req_in(idx_req_in), .idx_done_out(idx_done_out),
	.idx_new_out(idx_new_out), .tbl_addr_out(tbl_addr_out)
	);
	sba_mem_model u_mem (
	.clk_in(clk_in), .rst_n_in(rst_n_in), .stall_in(stall),
	.rd_valid_in(rd_valid_out), .rd_addr_in(rd_addr_out),
	.rd_ready_out(rd_ready_in), .rd_data_valid_out(rd_data_valid_in),
	.rd_data_out(rd_data_in), .wr_valid_in(wr_valid_out),
	.wr_in(wr_out), .wr_ready_out(wr_ready_in)
	);
	// ---------------------------------------------------------------
	// comparisons and the verdict
	// ---------------------------------------------------------------
	task automatic chk_bit(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_bit
	task automatic chk_val(input logic [159:0] got, input logic [159:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_val
	task automatic conclude();
		$display("checks=%0d mismatches=%0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude
	// ---------------------------------------------------------------
	// memory access and instruction issue
	// ---------------------------------------------------------------
	// fields sit sign byte first at their start byte
	task automatic load(input int at, input int n, input logic [159:0] d);
		for (int k = 0; k < n; k++) begin
			u_mem.m[at + k] = 8'(d >> (8 * (n - 1 - k)));
		end
	endtask : load
	function automatic logic [159:0] res(input int n);
		logic [159:0] d;
		d = '0;
		for (int k = 0; k < n; k++) begin
			d = {d[151:0], u_mem.m[32 + k]};
		end
		return d;
	endfunction : res
	// a at byte 0 (byte 4 when indexed), b at 16, c at 32
	task automatic run(input sba_row_t q);
		sba_issue_t t;
		t = '0;
		t.word[OPC_LSB +: 8] = q.op;
		t.word[SUBF_LSB +: 8] = 8'h00;
		t.word[XA_LSB +: 8] = q.x;
		t.word[RA_LSB +: 8] = 8'h01;
		t.a = '{len: q.la, base: 48'h0, index: 48'h4};
		t.b = '{len: q.lb, base: 48'h80, index: 48'h4};
		t.c = '{len: q.lc, base: 48'h100, index: 48'h4};
		load(q.x != 8'h00 ? 4 : 0, int'(q.la), 160'(q.a));
		load(16, int'(q.lb), 160'(q.b));
		load(32, 20, {20{8'h55}});
		@(posedge clk_in);
		issue_valid_in <= 1'b1;
		issue_in <= t;
		// ready is a register: high at the falling edge means high
		// at the next rising edge, where the take happens
		do @(negedge clk_in); while (issue_ready_out !== 1'b1);
		@(posedge clk_in);
		issue_valid_in <= 1'b0;
		got_ovf = 1'bx;
		for (int i = 0; i < 2000; i++) begin
			#1;
			if (done_out === 1'b1) begin
				got_ovf = ovf_flag_out;
				break;
			end
			@(posedge clk_in);
		end
		// done may come before the store queue has drained
		for (int i = 0; i < 200 && wr_valid_out !== 1'b0; i++) begin
			@(posedge clk_in);
		end
		repeat (2) @(posedge clk_in);
	endtask : run
	task automatic idx_case(input sba_idx_mode_t md, input logic [47:0] ini,
		input logic [47:0] nh, input logic dh, input logic [47:0] tb,
		input logic [7:0] ch, input logic [47:0] en, input logic [47:0] et);
		@(posedge clk_in);
		idx_valid_in <= 1'b1;
		idx_req_in <= '{md, ini, 48'h5, nh, dh, tb, ch};
		@(posedge clk_in);
		idx_valid_in <= 1'b0;
		#1;
		chk_bit(idx_done_out, 1'b1);
		chk_val(160'(idx_new_out), 160'(en));
		chk_val(160'(tbl_addr_out), 160'(et));
	endtask : idx_case
	// hang guard, well beyond the planned run
	initial begin
		#(50 * 20000);
		mismatches++;
		conclude();
	end
	initial begin
		rows = '{
		'{OPC_ADD, 16'h1, 16'h1, 16'h1, 8'h0, 64'h05, 64'h03, 160'h08, 1'b0},
		'{OPC_ADD, 16'h1, 16'h2, 16'h2, 8'h0, 64'hff, 64'h100, 160'hff, 1'b0},
		'{OPC_ADD, 16'h1, 16'h1, 16'h3, 8'h1, 64'h80, 64'h1, 160'hffff81, 1'b0},
		'{OPC_SUB, 16'h1, 16'h1, 16'h2, 8'h0, 64'h02, 64'h05, 160'hfffd, 1'b0},
		'{OPC_ADD, 16'h1, 16'h1, 16'h1, 8'h0, 64'h7f, 64'h01, 160'h0, 1'b1},
		'{OPC_MUL, 16'h1, 16'h1, 16'h2, 8'h0, 64'hfe, 64'h03, 160'hfffa, 1'b0},
		'{OPC_MUL, 16'h1, 16'h1, 16'h1, 8'h0, 64'h10, 64'h10, 160'h0, 1'b1},
		'{OPC_DIV, 16'h2, 16'h1, 16'h3, 8'h0, 64'hfff9, 64'h2, 160'hfffffd, 1'b0},
		'{OPC_DIV, 16'h2, 16'h1, 16'h4, 8'h0, 64'h64, 64'h7, 160'h200000e, 1'b0},
		'{OPC_DIV, 16'h1, 16'h1, 16'h2, 8'h0, 64'h05, 64'h00, 160'h0, 1'b1},
		'{OPC_ADD, 16'h0, 16'h1, 16'h1, 8'h0, 64'h00, 64'h05, 160'h05, 1'b0},
		'{OPC_SUB, 16'h9, 16'h1, 16'h1, 8'h0, 64'h01, 64'h01, 160'h0, 1'b1}};
		repeat (6) @(posedge clk_in);
		chk_bit(issue_ready_out, 1'b1);
		chk_bit(done_out | ovf_flag_out | rd_valid_out, 1'b0);
		rst_n_in <= 1'b1;
		foreach (rows[i]) begin
			r = rows[i];
			run(r);
			chk_bit(got_ovf, r.ovf);
			if (r.ovf === 1'b0) begin
				v = res(int'(r.lc));
				chk_val(v, r.c);
			end
		end
		// empty result leaves c untouched
		run('{OPC_ADD, 16'h1, 16'h1, 16'h0, 8'h0, 64'h1, 64'h1, 160'h0, 1'b0});
		chk_bit(got_ovf, 1'b0);
		chk_val(res(1), 160'h55);
		// long result against a stalled memory fills the queue
		stall <= 1'b1;
		fork
			begin
				repeat (150) @(negedge clk_in);
				chk_bit(wr_valid_out, 1'b1);
				chk_bit(issue_ready_out, 1'b0);
				@(posedge clk_in);
				stall <= 1'b0;
			end
		join_none
		run('{OPC_ADD, 16'h1, 16'h1, 16'h14, 8'h0, 64'h1, 64'h1, 160'h0, 1'b0});
		chk_val(res(20), 160'h2);
		idx_case(SBA_IDX_NONE, 48'ha, 48'h2, 1'b0, 48'h1000, 8'h41,
			48'ha, 48'h1258);
		idx_case(SBA_IDX_PART, 48'ha, 48'h3, 1'b0, 48'h0, 8'h0,
			48'hd, 48'h50);
		idx_case(SBA_IDX_FULL, 48'ha, 48'h3, 1'b0, 48'h0, 8'h1,
			48'hf, 48'h58);
		idx_case(SBA_IDX_FULL, 48'ha, 48'h3, 1'b1, 48'h0, 8'h2,
			48'h10, 48'h60);
		idx_case(SBA_IDX_NONE, 48'h0, 48'h0, 1'b0, 48'hffff_ffff_fff8, 8'h1,
			48'h0, 48'h0);
		conclude();
	end
endmodule : sba_unit_tb

// ===== verilog/sba_fifo.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// store queue between the datapath and memory
// ---------------------------------------------------------------
module sba_fifo #(
	parameter int WIDTH = 56,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	import sba_pkg::*;

	// storage and pointers, one extra pointer bit tells full from empty
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0] wp;
		logic [AW:0] rp;
	} sba_fifo_st_t;

	sba_fifo_st_t st_r; // registered state
	sba_fifo_st_t st_nxt; // next state
	logic [AW:0] used; // words held
	logic push; // accepted write
	logic pop; // accepted read

	assign used = st_r.wp - st_r.rp;
	assign in_ready_out = (used != (AW+1)'(DEPTH));
	assign out_valid_out = (used != '0);
	assign out_data_out = st_r.mem[st_r.rp[AW-1:0]];
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;

	// next pointers and write
	always_comb begin
		st_nxt = st_r;
		if (push) begin
			st_nxt.mem[st_r.wp[AW-1:0]] = in_data_in;
			st_nxt.wp = st_r.wp + 1'b1;
		end
		if (pop) begin
			st_nxt.rp = st_r.rp + 1'b1;
		end
	end

	// state register
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

endmodule : sba_fifo

// ===== verilog/sba_pkg.sv
// ---------------------------------------------------------------
// constants for the string binary arithmetic unit
// ---------------------------------------------------------------
package sba_pkg;

	// instruction word byte positions, opcode in the low byte
	localparam int OPC_LSB = 0;
	localparam int SUBF_LSB = 8;
	localparam int XA_LSB = 16; // index designator, field a
	localparam int RA_LSB = 24; // length/base designator, field a
	localparam int YB_LSB = 32;
	localparam int RB_LSB = 40;
	localparam int ZC_LSB = 48;
	localparam int RC_LSB = 56;

	// opcodes handled here
	localparam logic [7:0] OPC_ADD = 8'he0;
	localparam logic [7:0] OPC_SUB = 8'he1;
	localparam logic [7:0] OPC_MUL = 8'he2;
	localparam logic [7:0] OPC_DIV = 8'he3;

	localparam logic [7:0] NO_INDEX = 8'h00; // designator meaning none
	localparam int BYTE_SH = 3; // byte count to bit address
	localparam logic [47:0] BYTE_STEP = 48'h8;
	localparam logic [15:0] MAX_SRC_LEN = 16'h0008; // source bytes held
	localparam logic [15:0] WIDE_BYTES = 16'h0010; // working width
	localparam logic [6:0] DIV_STEPS = 7'h40; // one per dividend bit
	localparam int WR_DEPTH = 16; // store queue depth

	// termination state of an index register
	typedef enum logic [1:0] {
		SBA_IDX_NONE = 2'b00,
		SBA_IDX_PART = 2'b01,
		SBA_IDX_FULL = 2'b10
	} sba_idx_mode_t;

	// one field as read from the register file
	typedef struct packed {
		logic [15:0] len;
		logic [47:0] base; // bit address
		logic [47:0] index; // byte count
	} sba_field_t;

	// one issued instruction with its three fields
	typedef struct packed {
		logic [63:0] word;
		sba_field_t a;
		sba_field_t b;
		sba_field_t c;
	} sba_issue_t;

	// one byte store toward memory
	typedef struct packed {
		logic [47:0] addr;
		logic [7:0] data;
	} sba_wr_t;

	// index update request from a terminating string instruction
	typedef struct packed {
		sba_idx_mode_t mode;
		logic [47:0] init; // index at start
		logic [47:0] consumed; // data bytes used, delimiter excluded
		logic [47:0] no_hit; // equal compares before mismatch
		logic delim_hit; // field ended on its delimiter
		logic [47:0] tbl_base; // translate table base
		logic [7:0] chr; // character to translate
	} sba_idx_req_t;

	// byte of the instruction word at a bit position
	function automatic logic [7:0] sba_fld(input logic [63:0] w,
		input int lsb);
		return 8'(w >> lsb);
	endfunction : sba_fld

	// indexed start address; wrap of the sum is dropped
	function automatic logic [47:0] sba_eff_addr(input logic [47:0] base,
		input logic [47:0] idx, input logic [7:0] desig);
		if (desig == NO_INDEX) begin
			return base;
		end
		return base + (idx << BYTE_SH);
	endfunction : sba_eff_addr

endpackage : sba_pkg

// ===== verilog/sba_unit.sv
`timescale 1ns/1ps
module sba_unit (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic issue_valid_in,
	input sba_pkg::sba_issue_t issue_in,
	output logic issue_ready_out,
	output logic rd_valid_out,
	input wire logic rd_ready_in,
	output logic [47:0] rd_addr_out,
	input wire logic rd_data_valid_in,
	input wire logic [7:0] rd_data_in,
	output logic wr_valid_out,
	input wire logic wr_ready_in,
	output sba_pkg::sba_wr_t wr_out,
	output logic done_out,
	output logic ovf_flag_out,
	input wire logic idx_valid_in,
	input sba_pkg::sba_idx_req_t idx_req_in,
	output logic idx_done_out,
	output logic [47:0] idx_new_out,
	output logic [47:0] tbl_addr_out
);
	import sba_pkg::*;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		SBA_IDLE = 3'b000,
		SBA_LOAD_A = 3'b001,
		SBA_LOAD_B = 3'b010,
		SBA_EXEC = 3'b011,
		SBA_DIVIDE = 3'b100,
		SBA_STORE = 3'b101,
		SBA_FINISH = 3'b110
	} sba_fsm_t;

	typedef struct packed {
		sba_fsm_t fsm;
		logic [1:0] op; // low opcode bits
		logic [15:0] len_a;
		logic [15:0] len_b;
		logic [15:0] len_c;
		logic [15:0] cnt; // bytes moved in this phase
		logic [47:0] eb; // start of b
		logic [47:0] ec; // start of c
		logic [47:0] addr; // current byte address
		logic [63:0] acc; // bytes shifted in, msb first
		logic [63:0] va; // a, sign-extended
		logic [63:0] vb; // b, sign-extended
		logic [127:0] res; // sum, difference, product or quotient
		logic [127:0] rem; // divide remainder
		logic [64:0] dr; // partial remainder
		logic [63:0] dq; // dividend shifting into quotient
		logic [6:0] dstep;
		logic rd_valid; // read request standing
		logic rd_wait; // read taken, data pending
		logic ready;
		logic done;
		logic flag; // string arithmetic overflow
		logic ovf; // flag shown for the done cycle only
		logic wr_valid;
		sba_wr_t wr;
		logic idx_done;
		logic [47:0] idx_new;
		logic [47:0] tbl_addr;
	} sba_st_t;

	sba_st_t st_r; // registered state
	sba_st_t st_nxt; // next state
	logic q_ready; // store queue has room
	logic [127:0] wa; // a at working width
	logic [127:0] wb; // b at working width
	logic [63:0] ua; // |a|
	logic [63:0] ub; // |b|
	logic [64:0] dtry; // shifted partial remainder
	logic [15:0] len_q; // quotient bytes
	logic [7:0] obyte; // byte to store next

	// ---------------------------------------------------------------
	// arithmetic helpers
	// ---------------------------------------------------------------
	// sign-extend from n bytes; n of zero gives positive zero
	function automatic logic [127:0] sxt(input logic [127:0] v,
		input logic [15:0] n);
		logic [7:0] sh;
		sh = 8'h00;
		if (n >= WIDE_BYTES) begin
			return v;
		end
		sh = 8'((WIDE_BYTES - n) << BYTE_SH);
		return 128'($signed(v << sh) >>> sh);
	endfunction : sxt

	// value survives truncation to n bytes
	function automatic logic fits(input logic [127:0] v,
		input logic [15:0] n);
		return sxt(v, n) == v;
	endfunction : fits

	// byte j of an n-byte field, leftmost first, sign beyond width
	function automatic logic [7:0] byte_of(input logic [127:0] v,
		input logic [15:0] n, input logic [15:0] j);
		logic [15:0] k;
		k = n - 16'h0001 - j;
		if (k >= WIDE_BYTES) begin
			return {8{v[127]}};
		end
		return 8'(v >> {k[3:0], 3'b000});
	endfunction : byte_of

	// magnitude of a 64-bit value
	function automatic logic [63:0] mag(input logic [63:0] v);
		return v[63] ? 64'(-v) : v;
	endfunction : mag

	assign wa = {{64{st_r.va[63]}}, st_r.va};
	assign wb = {{64{st_r.vb[63]}}, st_r.vb};
	assign ua = mag(st_r.va);
	assign ub = mag(st_r.vb);
	assign dtry = {st_r.dr[63:0], st_r.dq[63]};
	assign len_q = st_r.len_c - st_r.len_b;

	// ---------------------------------------------------------------
	// byte selection for stores
	// ---------------------------------------------------------------
	// divide splits c: remainder then quotient
	always_comb begin
		obyte = byte_of(st_r.res, st_r.len_c, st_r.cnt);
		if (st_r.op == OPC_DIV[1:0]) begin
			if (st_r.cnt < st_r.len_b) begin
				obyte = byte_of(st_r.rem, st_r.len_b, st_r.cnt);
			end else begin
				obyte = byte_of(st_r.res, len_q,
					st_r.cnt - st_r.len_b);
			end
		end
	end

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	// software keeps c clear of a and b c is written
	// only after both sources are read, but overlap is not checked
	always_comb begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		st_nxt.idx_done = 1'b0;
		st_nxt.ovf = 1'b0;
		// queue handshake
		if (st_r.wr_valid && q_ready) begin
			st_nxt.wr_valid = 1'b0;
		end
		// read handshake shared by both load phases
		if (st_r.rd_valid && rd_ready_in) begin
			st_nxt.rd_valid = 1'b0;
			st_nxt.rd_wait = 1'b1;
		end
		if (st_r.rd_wait && rd_data_valid_in) begin
			st_nxt.rd_wait = 1'b0;
			st_nxt.acc = {st_r.acc[55:0], rd_data_in};
			st_nxt.cnt = st_r.cnt + 16'h0001;
			st_nxt.addr = st_r.addr + BYTE_STEP;
		end
		unique case (st_r.fsm)
			SBA_IDLE: begin
				if (issue_valid_in) begin
					// subfunction is not decoded; index is bytes
					st_nxt.ready = 1'b0;
					st_nxt.flag = 1'b0;
					st_nxt.op = 2'(sba_fld(issue_in.word, OPC_LSB));
					st_nxt.len_a = issue_in.a.len;
					st_nxt.len_b = issue_in.b.len;
					st_nxt.len_c = issue_in.c.len;
					st_nxt.cnt = '0;
					st_nxt.acc = '0;
					st_nxt.addr = sba_eff_addr(issue_in.a.base,
						issue_in.a.index,
						sba_fld(issue_in.word, XA_LSB));
					st_nxt.eb = sba_eff_addr(issue_in.b.base,
						issue_in.b.index,
						sba_fld(issue_in.word, YB_LSB));
					st_nxt.ec = sba_eff_addr(issue_in.c.base,
						issue_in.c.index,
						sba_fld(issue_in.word, ZC_LSB));
					if (issue_in.c.len == '0) begin
						st_nxt.fsm = SBA_FINISH;
					end else if (issue_in.a.len > MAX_SRC_LEN ||
						issue_in.b.len > MAX_SRC_LEN) begin
						// longer sources are beyond the held width
						st_nxt.flag = 1'b1;
						st_nxt.fsm = SBA_FINISH;
					end else begin
						st_nxt.fsm = SBA_LOAD_A;
					end
				end
			end
			SBA_LOAD_A: begin
				if (st_r.cnt == st_r.len_a && !st_r.rd_wait) begin
					st_nxt.va = 64'(sxt({64'h0, st_r.acc}, st_r.len_a));
					st_nxt.acc = '0;
					st_nxt.cnt = '0;
					st_nxt.addr = st_r.eb;
					st_nxt.fsm = SBA_LOAD_B;
				end else if (!st_r.rd_valid && !st_r.rd_wait) begin
					st_nxt.rd_valid = 1'b1;
				end
			end
			SBA_LOAD_B: begin
				if (st_r.cnt == st_r.len_b && !st_r.rd_wait) begin
					st_nxt.vb = 64'(sxt({64'h0, st_r.acc}, st_r.len_b));
					st_nxt.fsm = SBA_EXEC;
				end else if (!st_r.rd_valid && !st_r.rd_wait) begin
					st_nxt.rd_valid = 1'b1;
				end
			end
			SBA_EXEC: begin
				st_nxt.cnt = '0;
				st_nxt.addr = st_r.ec;
				st_nxt.fsm = SBA_STORE;
				unique case (st_r.op)
					OPC_ADD[1:0]: st_nxt.res = wa + wb;
					OPC_SUB[1:0]: st_nxt.res = wa - wb;
					OPC_MUL[1:0]: begin
						st_nxt.res = 128'($signed(wa) * $signed(wb));
					end
					OPC_DIV[1:0]: st_nxt.res = '0;
				endcase
				if (st_r.op == OPC_DIV[1:0]) begin
					st_nxt.dr = '0;
					st_nxt.dq = ua;
					st_nxt.dstep = '0;
					st_nxt.fsm = SBA_DIVIDE;
					if (st_r.vb == '0) begin
						st_nxt.flag = 1'b1;
						st_nxt.fsm = SBA_FINISH;
					end
				end else begin
					st_nxt.flag = !fits(st_nxt.res, st_r.len_c);
				end
			end
			SBA_DIVIDE: begin
				// restoring division on magnitudes, one bit a cycle
				if (st_r.dstep == DIV_STEPS) begin
					st_nxt.res = (st_r.va[63] ^ st_r.vb[63]) ?
						128'(-{64'h0, st_r.dq}) : {64'h0, st_r.dq};
					st_nxt.rem = st_r.va[63] ?
						128'(-{64'h0, st_r.dr[63:0]}) :
						{64'h0, st_r.dr[63:0]};
					st_nxt.flag = (st_r.len_c < st_r.len_b) ||
						!fits(st_nxt.res, len_q);
					st_nxt.fsm = SBA_STORE;
				end else begin
					st_nxt.dq = {st_r.dq[62:0], 1'b0};
					st_nxt.dr = dtry;
					if (dtry >= {1'b0, ub}) begin
						st_nxt.dr = dtry - {1'b0, ub};
						st_nxt.dq = {st_r.dq[62:0], 1'b1};
					end
					st_nxt.dstep = st_r.dstep + 7'h01;
				end
			end
			SBA_STORE: begin
				// a full queue holds the byte and stalls the walk
				if (!st_r.wr_valid || q_ready) begin
					if (st_r.cnt == st_r.len_c) begin
						st_nxt.fsm = SBA_FINISH;
					end else begin
						st_nxt.wr_valid = 1'b1;
						st_nxt.wr.addr = st_r.addr;
						st_nxt.wr.data = obyte;
						st_nxt.cnt = st_r.cnt + 16'h0001;
						st_nxt.addr = st_r.addr + BYTE_STEP;
					end
				end
			end
			SBA_FINISH: begin
				st_nxt.done = 1'b1;
				st_nxt.ovf = st_r.flag;
				st_nxt.ready = 1'b1;
				st_nxt.fsm = SBA_IDLE;
			end
			default: begin
				st_nxt.ready = 1'b1;
				st_nxt.fsm = SBA_IDLE;
			end
		endcase
		// -----------------------------------------------------------
		// index termination, independent of the arithmetic walk
		// -----------------------------------------------------------
		if (idx_valid_in) begin
			st_nxt.idx_done = 1'b1;
			st_nxt.tbl_addr = sba_eff_addr(idx_req_in.tbl_base,
				idx_req_in.init, 8'hff) +
				({40'h0, idx_req_in.chr} << BYTE_SH);
			unique case (idx_req_in.mode)
				SBA_IDX_PART: begin
					st_nxt.idx_new = idx_req_in.init +
						idx_req_in.no_hit;
				end
				SBA_IDX_FULL: begin
					st_nxt.idx_new = idx_req_in.init +
						idx_req_in.consumed +
						{47'h0, idx_req_in.delim_hit};
				end
				SBA_IDX_NONE: st_nxt.idx_new = idx_req_in.init;
				default: st_nxt.idx_new = idx_req_in.init;
			endcase
		end
	end

	// state register
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_r <= '0;
			st_r.ready <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ---------------------------------------------------------------
	// store queue
	// ---------------------------------------------------------------
	sba_fifo #(
		.WIDTH($bits(sba_wr_t)),
		.DEPTH(WR_DEPTH),
		.AW(4)
	) u_wrq (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.in_valid_in(st_r.wr_valid),
		.in_ready_out(q_ready),
		.in_data_in(st_r.wr),
		.out_valid_out(wr_valid_out),
		.out_ready_in(wr_ready_in),
		.out_data_out(wr_out)
	);

	// outputs straight from state
	assign issue_ready_out = st_r.ready;
	assign rd_valid_out = st_r.rd_valid;
	assign rd_addr_out = st_r.addr;
	assign done_out = st_r.done;
	assign ovf_flag_out = st_r.ovf;
	assign idx_done_out = st_r.idx_done;
	assign idx_new_out = st_r.idx_new;
	assign tbl_addr_out = st_r.tbl_addr;

endmodule : sba_unit
